// file: logic/lrmw_pkg.sv
// =====================================================================
// shared constants for the locked read-modify-write sequencer
// =====================================================================
package lrmw_pkg;

  // bus state machine: idle, read states, modify gap, write states
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_S0 = 4'h1,
    ST_S1 = 4'h2,
    ST_S2 = 4'h3,
    ST_S3 = 4'h4,
    ST_S4 = 4'h5,
    ST_S5 = 4'h6,
    ST_MOD = 4'h7,
    ST_S6 = 4'h8,
    ST_S7 = 4'h9,
    ST_S8 = 4'hA,
    ST_S9 = 4'hB,
    ST_S10 = 4'hC,
    ST_S11 = 4'hD
  } lrmw_state_t;

  // space code selecting cpu space
  localparam logic [2:0] LRMW_SPACE_CPU = 3'h7;
  // cpu space type field position and values
  localparam int LRMW_TYPE_LSB = 16;
  localparam int LRMW_TYPE_MSB = 19;
  localparam logic [3:0] LRMW_TYPE_BKPT = 4'h0;
  localparam logic [3:0] LRMW_TYPE_MODULE = 4'h1;
  localparam logic [3:0] LRMW_TYPE_COPROC = 4'h2;
  localparam logic [3:0] LRMW_TYPE_IACK = 4'hF;

  // address widths of the two variants
  localparam int LRMW_ADDR_W_FULL = 32;
  localparam int LRMW_ADDR_W_REDUCED = 24;
  localparam int LRMW_DATA_W = 32;

  // synchroniser depth for pin inputs
  localparam int LRMW_SYNC_STAGES = 2;

  // values after reset
  localparam logic LRMW_RST_NEG = 1'b1;
  localparam logic [2:0] LRMW_RST_CNT = 3'h0;

endpackage : lrmw_pkg

// file: logic/lrmw_sync.sv
`timescale 1ns/10ps
// =====================================================================
// two flip-flop synchroniser for pin inputs
// =====================================================================
module lrmw_sync
  import lrmw_pkg::*;
#(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  // clock and reset
  input wire logic mclk_in,
  input wire logic arst_n_in,
  input wire logic ce_in,
  // data
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta;
  logic [WIDTH-1:0] next_meta;
  logic [WIDTH-1:0] next_sync;

  always_comb begin
    next_meta = ce_in ? async_in : meta;
    next_sync = ce_in ? meta : sync_out;
  end

  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      meta <= RST_VAL;
      sync_out <= RST_VAL;
    end else begin
      meta <= next_meta;
      sync_out <= next_sync;
    end
  end

endmodule : lrmw_sync

// file: logic/lrmw_sequencer.sv
`timescale 1ns/10ps
// How it works
// [RULE_01] first read S0 asserts lock, and on full variant both cycle-start strobes
// [RULE_02] S0 presents address, space code, size, and read level on read_write_n
// [RULE_03] address is 32 bits on full variant, 24 on reduced
// [RULE_04] S1 asserts address and data strobes, drops cycle-start strobes
// [RULE_05] full variant asserts buffer enable from S2 of each read
// [RULE_06] slave drives read data on lanes chosen by size and low address
// [RULE_07] acknowledge seen by end of S2 ends read with no wait states
// [RULE_08] no acknowledge by S3 inserts wait states, resampling every cycle
// [RULE_09] slave holds both acknowledge lines negated to force waits
// [RULE_10] read data captured at end of S4
// [RULE_11] S5 negates strobes and buffer enable; repeat reads; hold address
// [RULE_12] slave releases data and acknowledge within a clock after strobes drop
// [RULE_13] idle gap asserts nothing new; writes skipped when not needed
// [RULE_14] read level held until S6, data bus not driven before S8
// [RULE_15] S6 drives write level, may change address, asserts cycle-start strobes
// [RULE_16] S7 asserts address strobe and buffer enable, drops cycle-start strobes
// [RULE_17] write data driven in S8, data strobe asserted in S9
// [RULE_18] acknowledge by S8 ends write a clock later, else wait states
// [RULE_19] slave stores only selected lanes and acknowledges once stored
// [RULE_20] S11 negates strobes, holds address and data; repeat writes
// [RULE_21] space code 111 marks a cpu space cycle
// [RULE_22] cpu space type goes on address bits 19..16; four types valid
// [RULE_23] no bus grant while any part of the locked sequence runs
// [RULE_24] failed compare omits the write cycles
// [RULE_25] type 1111 is interrupt acknowledge
// [RULE_26] type 0010 is coprocessor communication
// [RULE_27] lock held continuously from first S0 until last cycle ends
module lrmw_sequencer
  import lrmw_pkg::*;
#(
  parameter bit FULL_VARIANT = 1'b1,
  // [RULE_03] address width per variant
  parameter int ADDR_W = FULL_VARIANT ? LRMW_ADDR_W_FULL : LRMW_ADDR_W_REDUCED,
  parameter int CNT_W = 3
) (
  // clock, reset, enable
  input wire logic mclk_in,
  input wire logic arst_n_in,
  input wire logic ce_in,
  // internal request side
  input wire logic start_in,
  input wire logic [ADDR_W-1:0] rd_addr_in,
  input wire logic [2:0] space_code_in,
  input wire logic [1:0] xfer_size_in,
  input wire logic [CNT_W-1:0] rd_count_in,
  input wire logic [CNT_W-1:0] wr_count_in,
  input wire logic mod_ready_in,
  input wire logic mod_write_in,
  input wire logic [ADDR_W-1:0] wr_addr_in,
  input wire logic [LRMW_DATA_W-1:0] wr_data_in,
  output logic busy_out,
  output logic done_out,
  output logic rd_valid_out,
  output logic [LRMW_DATA_W-1:0] rd_data_out,
  output logic wr_taken_out,
  output logic cpu_space_out,
  output logic iack_cycle_out,
  output logic coproc_cycle_out,
  output logic type_reserved_out,
  // external bus pins
  output logic [ADDR_W-1:0] addr_out,
  output logic [2:0] space_code_out,
  output logic [1:0] xfer_size_out,
  output logic read_write_n_out,
  output logic locked_cycle_n_out,
  output logic ext_cycle_start_n_out,
  output logic operand_cycle_start_n_out,
  output logic addr_strobe_n_out,
  output logic data_strobe_n_out,
  output logic buffer_enable_n_out,
  input wire logic [1:0] size_ack_n_in,
  input wire logic [LRMW_DATA_W-1:0] data_in,
  output logic [LRMW_DATA_W-1:0] data_out,
  output logic data_oe_out,
  // bus arbitration
  input wire logic bus_request_in,
  output logic bus_grant_out
);

  // ===================================================================
  // type decode
  // ===================================================================
  function automatic logic type_known(input logic [3:0] t);
    type_known = (t == LRMW_TYPE_BKPT) || (t == LRMW_TYPE_MODULE) ||
                 (t == LRMW_TYPE_COPROC) || (t == LRMW_TYPE_IACK);
  endfunction : type_known

  function automatic logic in_write(input lrmw_state_t s);
    in_write = (s >= ST_S6) && (s <= ST_S11);
  endfunction : in_write

  // ===================================================================
  // pin synchronisers
  // ===================================================================
  localparam int SYNC_W = LRMW_DATA_W + 3;
  logic [SYNC_W-1:0] pins_sync;
  logic [1:0] ack_sync_n;
  logic [LRMW_DATA_W-1:0] data_sync;
  logic breq_sync;
  logic ack_rec;

  lrmw_sync #(
    .WIDTH(SYNC_W),
    .RST_VAL({{(LRMW_DATA_W+1){1'b0}}, 2'b11})
  ) u_sync (
    .mclk_in(mclk_in),
    .arst_n_in(arst_n_in),
    .ce_in(ce_in),
    .async_in({bus_request_in, data_in, size_ack_n_in}),
    .sync_out(pins_sync)
  );

  assign ack_sync_n = pins_sync[1:0];
  assign data_sync = pins_sync[LRMW_DATA_W+1:2];
  assign breq_sync = pins_sync[SYNC_W-1];
  assign ack_rec = ~(&ack_sync_n);

  // ===================================================================
  // sequencer state
  // ===================================================================
  lrmw_state_t state, next_state;
  logic [CNT_W-1:0] rd_left, next_rd_left, wr_left, next_wr_left;
  logic granted, next_granted, accept;

  // requests wait while the bus is handed away
  assign accept = start_in && (state == ST_IDLE) && !granted && (rd_count_in != LRMW_RST_CNT);

  always_comb begin
    next_state = state;
    next_rd_left = rd_left;
    next_wr_left = wr_left;
    next_granted = granted;
    case (state)
      ST_IDLE: begin
        // [RULE_23] grant only outside sequence
        next_granted = breq_sync && (granted || !start_in);
        if (accept) begin
          next_state = ST_S0;
          next_rd_left = rd_count_in;
          next_wr_left = wr_count_in;
        end
      end
      ST_S0: next_state = ST_S1;
      ST_S1: next_state = ST_S2;
      // [RULE_07] early acknowledge, no waits
      ST_S2: next_state = ST_S3;
      ST_S3: begin
        // [RULE_08] wait until acknowledge
        if (ack_rec) begin
          next_state = ST_S4;
        end
      end
      ST_S4: next_state = ST_S5;
      ST_S5: begin
        // [RULE_11] further reads repeat S0..S5
        next_rd_left = CNT_W'(rd_left - 1'b1);
        next_state = (rd_left > CNT_W'(1)) ? ST_S0 : ST_MOD;
      end
      ST_MOD: begin
        // [RULE_13] gap waits for modify step
        // [RULE_24] failed compare skips writes
        if (mod_ready_in) begin
          next_state = (mod_write_in && (wr_left != LRMW_RST_CNT)) ? ST_S6 : ST_IDLE;
        end
      end
      ST_S6: next_state = ST_S7;
      ST_S7: next_state = ST_S8;
      ST_S8: next_state = ST_S9;
      ST_S9: begin
        // [RULE_18] wait states before S10
        if (ack_rec) begin
          next_state = ST_S10;
        end
      end
      ST_S10: next_state = ST_S11;
      ST_S11: begin
        // [RULE_20] further writes repeat S6..S11
        next_wr_left = CNT_W'(wr_left - 1'b1);
        next_state = (wr_left > CNT_W'(1)) ? ST_S6 : ST_IDLE;
      end
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state <= ST_IDLE;
      rd_left <= LRMW_RST_CNT;
      wr_left <= LRMW_RST_CNT;
      granted <= 1'b0;
    end else if (ce_in) begin
      state <= next_state;
      rd_left <= next_rd_left;
      wr_left <= next_wr_left;
      granted <= next_granted;
    end
  end

  // ===================================================================
  // pin outputs, registered from next state
  // ===================================================================
  logic next_locked_n, next_ecs_n, next_as_n, next_ds_n, next_buffer_enable_n_n, next_rw_n, next_oe;
  logic [ADDR_W-1:0] next_addr;
  logic [2:0] next_space;
  logic [1:0] next_size;
  logic [LRMW_DATA_W-1:0] next_wdata, next_rdata;
  logic next_rd_valid, next_done, next_wr_taken;

  always_comb begin
    // [RULE_27] lock held for whole sequence
    next_locked_n = (next_state == ST_IDLE);
    // [RULE_01] cycle start in S0 and S6
    next_ecs_n = !(FULL_VARIANT && ((next_state == ST_S0) || (next_state == ST_S6)));
    // [RULE_04] strobes from S1, dropped in S5
    next_as_n = !(((next_state >= ST_S1) && (next_state <= ST_S4)) ||
                  ((next_state >= ST_S7) && (next_state <= ST_S10)));
    // [RULE_17] write data strobe from S9
    next_ds_n = !(((next_state >= ST_S1) && (next_state <= ST_S4)) ||
                  (next_state == ST_S9) || (next_state == ST_S10));
    // [RULE_16] S7 strobe and buffer enable
    // [RULE_05] buffers enabled from S2 and S7
    next_buffer_enable_n_n = !(FULL_VARIANT && (((next_state >= ST_S2) && (next_state <= ST_S4)) ||
                                     ((next_state >= ST_S7) && (next_state <= ST_S11))));
    // [RULE_14] read level until S6
    next_rw_n = !in_write(next_state);
    next_oe = (next_state >= ST_S8) && (next_state <= ST_S11);
    next_addr = addr_out;
    next_space = space_code_out;
    next_size = xfer_size_out;
    next_wdata = data_out;
    next_rdata = rd_data_out;
    next_rd_valid = 1'b0;
    next_wr_taken = 1'b0;
    next_done = (state != ST_IDLE) && (next_state == ST_IDLE);
    // [RULE_02] address, space and size valid in S0
    if (accept) begin
      next_addr = rd_addr_in;
      next_space = space_code_in;
      next_size = xfer_size_in;
    end
    // [RULE_15] address may change entering S6
    if (next_state == ST_S6) begin
      next_addr = wr_addr_in;
    end
    // [RULE_17] data driven from S8, held through S11
    if ((state == ST_S7) && (next_state == ST_S8)) begin
      next_wdata = wr_data_in;
      next_wr_taken = 1'b1;
    end
    // [RULE_10] capture at end of S4
    if (state == ST_S4) begin
      next_rdata = data_sync;
      next_rd_valid = 1'b1;
    end
  end

  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      locked_cycle_n_out <= LRMW_RST_NEG;
      ext_cycle_start_n_out <= LRMW_RST_NEG;
      addr_strobe_n_out <= LRMW_RST_NEG;
      data_strobe_n_out <= LRMW_RST_NEG;
      buffer_enable_n_out <= LRMW_RST_NEG;
      read_write_n_out <= LRMW_RST_NEG;
      data_oe_out <= 1'b0;
      addr_out <= '0;
      space_code_out <= '0;
      xfer_size_out <= '0;
      data_out <= '0;
      rd_data_out <= '0;
      rd_valid_out <= 1'b0;
      wr_taken_out <= 1'b0;
      done_out <= 1'b0;
    end else if (ce_in) begin
      locked_cycle_n_out <= next_locked_n;
      ext_cycle_start_n_out <= next_ecs_n;
      addr_strobe_n_out <= next_as_n;
      data_strobe_n_out <= next_ds_n;
      buffer_enable_n_out <= next_buffer_enable_n_n;
      read_write_n_out <= next_rw_n;
      data_oe_out <= next_oe;
      addr_out <= next_addr;
      space_code_out <= next_space;
      xfer_size_out <= next_size;
      data_out <= next_wdata;
      rd_data_out <= next_rdata;
      rd_valid_out <= next_rd_valid;
      wr_taken_out <= next_wr_taken;
      done_out <= next_done;
    end
  end

  assign operand_cycle_start_n_out = ext_cycle_start_n_out;
  assign busy_out = (state != ST_IDLE);
  assign bus_grant_out = granted;

  // ===================================================================
  // cpu space classification
  // ===================================================================
  logic [3:0] cur_type;
  assign cur_type = addr_out[LRMW_TYPE_MSB:LRMW_TYPE_LSB];
  // [RULE_21] space code 111
  assign cpu_space_out = (space_code_out == LRMW_SPACE_CPU);
  // [RULE_25] interrupt acknowledge type
  assign iack_cycle_out = cpu_space_out && (cur_type == LRMW_TYPE_IACK);
  // [RULE_26] coprocessor type
  assign coproc_cycle_out = cpu_space_out && (cur_type == LRMW_TYPE_COPROC);
  // [RULE_22] other types reserved
  assign type_reserved_out = cpu_space_out && !type_known(cur_type);

  // ===================================================================
  // checks
  // ===================================================================
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!arst_n_in || !ce_in);

  sequence s_read_acked;
    (state == ST_S3) && ack_rec ##1 (state == ST_S4) ##1 (state == ST_S5);
  endsequence

  sequence s_write_tail;
    (state == ST_S10) && !addr_strobe_n_out ##1 (state == ST_S11) && addr_strobe_n_out && data_oe_out;
  endsequence

  a_start_lock: assert property (accept |=> !locked_cycle_n_out && (ext_cycle_start_n_out == !FULL_VARIANT)) // RULE_01
    else $error("lock or cycle start missing in S0");
  a_s0_read_lvl: assert property ((state == ST_S0) |-> read_write_n_out && (addr_out == $past(rd_addr_in))) // RULE_02
    else $error("S0 address or direction wrong");
  a_s1_strobes: assert property ((state == ST_S0) |=> !addr_strobe_n_out && !data_strobe_n_out && ext_cycle_start_n_out) // RULE_04
    else $error("S1 strobes wrong");
  a_read_buffer_enable_n: assert property ((state == ST_S2) |-> (buffer_enable_n_out == !FULL_VARIANT)) // RULE_05
    else $error("buffer enable missing in S2");
  a_read_nowait: assert property ((state == ST_S3) && ack_rec |-> s_read_acked) // RULE_07
    else $error("acknowledged read did not finish");
  a_read_wait: assert property ((state == ST_S3) && !ack_rec |=> (state == ST_S3) && !addr_strobe_n_out) // RULE_08
    else $error("wait state not inserted");
  a_read_capture: assert property ((state == ST_S4) |=> rd_valid_out && (rd_data_out == $past(data_sync))) // RULE_10
    else $error("read data not captured at S4");
  a_s5_negate: assert property ((state == ST_S5) |-> addr_strobe_n_out && data_strobe_n_out && buffer_enable_n_out) // RULE_11
    else $error("strobes not negated in S5");
  a_gap_quiet: assert property ((state == ST_MOD) |-> addr_strobe_n_out && read_write_n_out && !data_oe_out) // RULE_13
    else $error("signals asserted in idle gap");
  a_no_early_drive: assert property (data_oe_out |-> (state >= ST_S8) && (state <= ST_S11)) // RULE_14
    else $error("data bus driven outside S8..S11");
  a_write_ds: assert property ((state == ST_S8) |=> !data_strobe_n_out ##0 $stable(data_out)) // RULE_17
    else $error("data strobe not asserted in S9");
  a_write_end: assert property ((state == ST_S9) && ack_rec |=> s_write_tail) // RULE_20
    else $error("write did not end correctly");
  a_skip_write: assert property ((state == ST_MOD) && mod_ready_in && !mod_write_in |=> (state == ST_IDLE)) // RULE_24
    else $error("failed compare still wrote");
  a_grant_lock: assert property (!locked_cycle_n_out |-> !bus_grant_out) // RULE_23
    else $error("bus granted during locked sequence");
  a_lock_steady: assert property (busy_out |-> !locked_cycle_n_out ##1 (busy_out || locked_cycle_n_out)) // RULE_27
    else $error("lock dropped inside sequence");

endmodule : lrmw_sequencer

// file: bench/lrmw_bench_fn.svh
`ifndef LRMW_BENCH_FN_SVH
`define LRMW_BENCH_FN_SVH
// byte lanes of a 32-bit port for a size code and low address
function automatic logic [31:0] lrmw_lanes(input logic [1:0] sz, input logic [1:0] off);
  int n;
  lrmw_lanes = 32'h0;
  n = (sz == 2'h0) ? 4 : int'(sz);
  for (int k = 0; k < 4; k++) begin
    if (k >= int'(off) && k < int'(off) + n) lrmw_lanes[31-8*k -: 8] = 8'hFF;
  end
endfunction : lrmw_lanes
// word the slave returns on its n-th read
function automatic logic [31:0] lrmw_rd_word(input logic [31:0] a, input int n);
  lrmw_rd_word = a ^ 32'hC3A5_0000 ^ 32'(n);
endfunction : lrmw_rd_word
`endif

// file: bench/lrmw_slave.sv
`timescale 1ns/10ps
// =====================================================================
// memory slave on the asynchronous bus, 32-bit port
// =====================================================================
module lrmw_slave (
  // clock
  input wire logic mclk_in,
  // bus from the sequencer
  input wire logic [31:0] addr_in,
  input wire logic [1:0] xfer_size_in,
  input wire logic read_write_n_in,
  input wire logic addr_strobe_n_in,
  input wire logic data_strobe_n_in,
  input wire logic [31:0] data_in,
  input wire logic [2:0] wait_in,
  // answer
  output logic [1:0] size_ack_n_out,
  output logic [31:0] data_out
);
  logic [31:0] mem [0:63];
  logic [31:0] m;
  int wcnt = 0;
  int rcnt = 0;
  initial begin
    size_ack_n_out = 2'h3;
    data_out = 32'h0;
    for (int i = 0; i < 64; i++) mem[i] = 32'h0;
  end
  // byte lanes picked by size and low address
  always_comb begin
    m = 32'h0;
    for (int k = 0; k < 4; k++) begin
      if (k >= int'(addr_in[1:0]) && k < int'(addr_in[1:0]) + ((xfer_size_in == 2'h0) ? 4 : int'(xfer_size_in)))
        m[31-8*k -: 8] = 8'hFF;
    end
  end
  always @(posedge mclk_in) begin
    if (addr_strobe_n_in || data_strobe_n_in) begin
      // release ack and data after strobes drop
      wcnt <= 0;
      size_ack_n_out <= 2'h3;
      data_out <= ~data_out;
    end else if (wcnt < int'(wait_in)) begin
      wcnt <= wcnt + 1;
      data_out <= ~data_out;
    end else if (size_ack_n_out == 2'h3) begin
      size_ack_n_out <= 2'h0;
      if (read_write_n_in) begin
        data_out <= ((addr_in ^ 32'hC3A5_0000 ^ 32'(rcnt)) & m) | (~data_out & ~m);
        rcnt <= rcnt + 1;
      end else begin
        mem[addr_in[7:2]] <= (mem[addr_in[7:2]] & ~m) | (data_in & m);
      end
    end
  end
endmodule : lrmw_slave

// file: bench/test_locked_rmw_bus_sequencer.sv
`timescale 1ns/10ps
// =====================================================================
// self-checking bench for the locked read-modify-write sequencer
// =====================================================================
module test_locked_rmw_bus_sequencer
  import lrmw_pkg::*;
;
  `include "lrmw_bench_fn.svh"
  logic mclk_in = 1'b0;
  logic arst_n_in, start_in, mod_ready_in, mod_write_in, bus_request_in;
  logic [31:0] rd_addr_in, wr_addr_in, wr_data_in, rd_data_out, addr_out, data_in, data_out;
  logic [2:0] space_code_in, rd_count_in, wr_count_in, space_code_out, wt, sc;
  logic [1:0] xfer_size_in, xfer_size_out, size_ack_n_in, sz;
  logic busy_out, done_out, rd_valid_out, wr_taken_out, cpu_space_out, iack_cycle_out;
  logic coproc_cycle_out, type_reserved_out, read_write_n_out, locked_cycle_n_out;
  logic ext_cycle_start_n_out, operand_cycle_start_n_out, addr_strobe_n_out;
  logic data_strobe_n_out, buffer_enable_n_out, data_oe_out, bus_grant_out;
  logic [31:0] ra, m;
  logic [31:0] wa [0:1];
  logic [31:0] wd [0:1];
  logic [31:0] exp_mem [0:63];
  logic [3:0] types [0:4];
  logic wrt, cpu, prev_lock, prev_as, prev_ds;
  int nr, nw, nrd, mr, mw, fails, checks;

  lrmw_sequencer i_lrmw_sequencer (
    .mclk_in(mclk_in), .arst_n_in(arst_n_in), .ce_in(1'b1), .start_in(start_in),
    .rd_addr_in(rd_addr_in), .space_code_in(space_code_in), .xfer_size_in(xfer_size_in),
    .rd_count_in(rd_count_in), .wr_count_in(wr_count_in), .mod_ready_in(mod_ready_in),
    .mod_write_in(mod_write_in), .wr_addr_in(wr_addr_in), .wr_data_in(wr_data_in),
    .busy_out(busy_out), .done_out(done_out), .rd_valid_out(rd_valid_out), .rd_data_out(rd_data_out),
    .wr_taken_out(wr_taken_out), .cpu_space_out(cpu_space_out), .iack_cycle_out(iack_cycle_out),
    .coproc_cycle_out(coproc_cycle_out), .type_reserved_out(type_reserved_out), .addr_out(addr_out),
    .space_code_out(space_code_out), .xfer_size_out(xfer_size_out), .read_write_n_out(read_write_n_out),
    .locked_cycle_n_out(locked_cycle_n_out), .ext_cycle_start_n_out(ext_cycle_start_n_out),
    .operand_cycle_start_n_out(operand_cycle_start_n_out), .addr_strobe_n_out(addr_strobe_n_out),
    .data_strobe_n_out(data_strobe_n_out), .buffer_enable_n_out(buffer_enable_n_out),
    .size_ack_n_in(size_ack_n_in), .data_in(data_in), .data_out(data_out), .data_oe_out(data_oe_out),
    .bus_request_in(bus_request_in), .bus_grant_out(bus_grant_out));

  lrmw_slave i_lrmw_slave (
    .mclk_in(mclk_in), .addr_in(addr_out), .xfer_size_in(xfer_size_out), .read_write_n_in(read_write_n_out),
    .addr_strobe_n_in(addr_strobe_n_out), .data_strobe_n_in(data_strobe_n_out), .data_in(data_out),
    .wait_in(wt), .size_ack_n_out(size_ack_n_in), .data_out(data_in));

  initial begin
    forever #5 mclk_in = ~mclk_in;
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic tick();
    @(posedge mclk_in);
    #1;
  endtask : tick

  task automatic finish_test();
    if (fails == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : finish_test

  initial begin
    #300000;
    fails++;
    finish_test();
  end

  // =====================================================================
  // pin monitor
  // =====================================================================
  always @(posedge mclk_in) begin
    #2;
    if (arst_n_in === 1'b1) begin
      if (busy_out === 1'b1) check("grant busy", bus_grant_out, 0);
      if (busy_out === 1'b1 && prev_lock === 1'b0) check("lock held", locked_cycle_n_out, 0);
      check("ocs copy", operand_cycle_start_n_out, ext_cycle_start_n_out);
      if (ext_cycle_start_n_out === 1'b0) begin
        check("ecs as", addr_strobe_n_out, 1);
        check("ecs lock", locked_cycle_n_out, 0);
        check("ecs addr", addr_out, read_write_n_out ? ra : wa[mw]);
        check("ecs code", {space_code_out, xfer_size_out}, {sc, sz});
      end
      if (data_oe_out === 1'b1) check("oe rw", read_write_n_out, 0);
      if (read_write_n_out === 1'b1 && data_strobe_n_out === 1'b0 && prev_ds === 1'b0)
        check("buffer_enable_n", buffer_enable_n_out, 0);
      if (read_write_n_out === 1'b0 && data_strobe_n_out === 1'b0) check("wdata", data_out, wd[mw-1]);
      if (read_write_n_out === 1'b0 && addr_strobe_n_out === 1'b1 && prev_as === 1'b0) begin
        check("s11 hold", {data_oe_out, data_strobe_n_out}, 2'h3);
        check("s11 data", data_out, wd[mw-1]);
      end
      if (rd_valid_out === 1'b1) begin
        m = lrmw_lanes(sz, ra[1:0]);
        check("rd data", rd_data_out & m, lrmw_rd_word(ra, nrd) & m);
        check("s5 strobes", {addr_strobe_n_out, data_strobe_n_out, buffer_enable_n_out}, 3'h7);
        mr++;
        nrd++;
      end
      if (wr_taken_out === 1'b1) mw++;
      if (busy_out === 1'b1) begin
        cpu = (sc == LRMW_SPACE_CPU);
        check("cpu", cpu_space_out, cpu);
        check("iack", iack_cycle_out, cpu && addr_out[19:16] == LRMW_TYPE_IACK);
        check("coproc", coproc_cycle_out, cpu && addr_out[19:16] == LRMW_TYPE_COPROC);
        check("reserved", type_reserved_out, cpu && !(addr_out[19:16] inside {LRMW_TYPE_BKPT,
          LRMW_TYPE_MODULE, LRMW_TYPE_COPROC, LRMW_TYPE_IACK}));
      end
    end
    prev_lock = locked_cycle_n_out;
    prev_as = addr_strobe_n_out;
    prev_ds = data_strobe_n_out;
  end

  // =====================================================================
  // main sequence
  // =====================================================================
  initial begin
    {arst_n_in, start_in, mod_ready_in, mod_write_in, bus_request_in} = 5'h0;
    {rd_addr_in, wr_addr_in, wr_data_in, space_code_in, xfer_size_in} = '0;
    {rd_count_in, wr_count_in, wt, sc, sz, ra} = '0;
    types = '{LRMW_TYPE_BKPT, LRMW_TYPE_MODULE, LRMW_TYPE_COPROC, LRMW_TYPE_IACK, 4'h9};
    for (int i = 0; i < 64; i++) exp_mem[i] = 32'h0;
    {nrd, mr, mw, fails, checks} = '0;
    void'($urandom(32'hC8A8));
    repeat (3) tick();
    arst_n_in = 1'b1;
    tick();
    check("reset pins", {locked_cycle_n_out, addr_strobe_n_out, data_strobe_n_out, data_oe_out,
      bus_grant_out}, 5'h1C);
    for (int op = 0; op < 24; op++) begin
      ra = $urandom;
      sz = 2'($urandom);
      sc = 3'($urandom);
      if (op % 3 == 0) begin
        sc = LRMW_SPACE_CPU;
        ra[19:16] = types[(op / 3) % 5];
      end
      nr = 1 + $urandom % 3;
      nw = 1 + $urandom % 2;
      wrt = 1'($urandom);
      wt = 3'($urandom % 4);
      for (int k = 0; k < 2; k++) begin
        wa[k] = $urandom;
        wd[k] = $urandom;
      end
      mr = 0;
      mw = 0;
      {rd_addr_in, space_code_in, xfer_size_in} = {ra, sc, sz};
      {rd_count_in, wr_count_in, wr_addr_in, wr_data_in} = {3'(nr), 3'(nw), wa[0], wd[0]};
      bus_request_in = 1'($urandom);
      start_in = 1'b1;
      tick();
      start_in = 1'b0;
      for (int t = 0; t < 100 && mr < nr; t++) tick();
      repeat ($urandom % 4) tick();
      mod_ready_in = 1'b1;
      mod_write_in = wrt;
      for (int t = 0; t < 200 && done_out !== 1'b1; t++) begin
        tick();
        if (wr_taken_out === 1'b1) {wr_addr_in, wr_data_in} = {wa[1], wd[1]};
      end
      check("done", done_out, 1);
      check("reads", mr, nr);
      check("writes", mw, wrt ? nw : 0);
      for (int k = 0; k < nw && wrt; k++) begin
        m = lrmw_lanes(sz, wa[k][1:0]);
        exp_mem[wa[k][7:2]] = (exp_mem[wa[k][7:2]] & ~m) | (wd[k] & m);
      end
      for (int k = 0; k < nw; k++) check("mem", i_lrmw_slave.mem[wa[k][7:2]], exp_mem[wa[k][7:2]]);
      mod_ready_in = 1'b0;
      bus_request_in = 1'b0;
      repeat (8) tick();
    end
    bus_request_in = 1'b1;
    repeat (6) tick();
    check("grant idle", bus_grant_out, 1);
    start_in = 1'b1;
    tick();
    start_in = 1'b0;
    tick();
    check("start refused", busy_out, 0);
    bus_request_in = 1'b0;
    repeat (8) tick();
    start_in = 1'b1;
    tick();
    start_in = 1'b0;
    repeat (3) tick();
    arst_n_in = 1'b0;
    #1;
    check("mid reset", {locked_cycle_n_out, addr_strobe_n_out, busy_out}, 3'h6);
    tick();
    arst_n_in = 1'b1;
    repeat (4) tick();
    start_in = 1'b1;
    tick();
    start_in = 1'b0;
    check("restart", {busy_out, locked_cycle_n_out}, 2'h2);
    finish_test();
  end
endmodule : test_locked_rmw_bus_sequencer
